// file: pes_pkg.sv
// Constants for the event status and error counter register bank.
// Assumes a 32-bit register bus with aligned word registers.
package pes_pkg;

	// ----------------------------------------------------------------
	// Register indices (byte address is four times the index)
	// ----------------------------------------------------------------
	localparam logic [5:0] IDX_STAT1 = 6'h12;
	localparam logic [5:0] IDX_STAT2 = 6'h13;
	localparam logic [5:0] IDX_FCNT = 6'h14;
	localparam logic [5:0] IDX_RXERR = 6'h15;
	localparam logic [5:0] IDX_STC = 6'h16;

	// ----------------------------------------------------------------
	// Field positions of the second status and enable register
	// ----------------------------------------------------------------
	localparam int BIT_UV = 15;
	localparam int BIT_OV = 14;
	localparam int BIT_OT = 11;
	localparam int BIT_SLEEP = 10;
	localparam int BIT_POL = 9;
	localparam int BIT_JAB = 8;
	localparam int EN_UV = 7;
	localparam int EN_OV = 6;
	localparam int EN_OT = 3;
	localparam int EN_SLEEP = 2;
	localparam int EN_POL = 1;
	localparam int EN_JAB = 0;

	// ----------------------------------------------------------------
	// Field positions of the first status and enable register
	// ----------------------------------------------------------------
	localparam int BIT_FC_HF = 9;
	localparam int BIT_RX_HF = 8;
	localparam int EN_FC_HF = 1;
	localparam int EN_RX_HF = 0;

	// ----------------------------------------------------------------
	// Writable masks and reset values
	// ----------------------------------------------------------------
	localparam logic [15:0] EN2_MASK = 16'h00CF;
	localparam logic [15:0] EN1_MASK = 16'h0003;
	localparam logic [15:0] STC_MASK = 16'h707F;
	localparam logic [15:0] STC_RSV_VAL = 16'h0180 & 16'h0100;
	localparam logic [15:0] REG_RST = 16'h0000;

	// ----------------------------------------------------------------
	// Counter sizes and thresholds
	// ----------------------------------------------------------------
	localparam int FC_W = 8;
	localparam int RX_W = 16;
	localparam logic [7:0] FC_MAX = 8'hFF;
	localparam logic [7:0] FC_HALF = 8'h7F;
	localparam logic [15:0] RX_MAX = 16'h0FFF;
	localparam logic [15:0] RX_HALF = 16'h7FFF;

endpackage : pes_pkg

// file: pes_cnt_if.sv
// Carrier between the register bank and one saturating counter.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
interface pes_cnt_if #(
	parameter int W = 16
);
	logic inc; // One count this cycle
	logic clr; // Clear on read this cycle
	logic [W-1:0] count; // Current count
	logic half_evt; // One-cycle pulse on passing half-full

	// Counter end
	modport ctr (input inc, input clr, output count, output half_evt);
	// Register bank end
	modport user (output inc, output clr, input count, input half_evt);
endinterface : pes_cnt_if

// file: pes_sat_counter.sv
// Saturating event counter with clear on read and half-full pulse.
// Assumes inc and clr are synchronous single-cycle strobes.
`timescale 1ns/1ps
module pes_sat_counter #(
	parameter int W = 16,
	parameter logic [W-1:0] MAX = {W{1'b1}},
	parameter logic [W-1:0] HALF = {1'b0, {(W-1){1'b1}}}
) (
	// Clock, reset and enable
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Counter carrier
	pes_cnt_if.ctr cnt
);

	// ----------------------------------------------------------------
	// Next-state decode
	// ----------------------------------------------------------------
	logic [W-1:0] next_count; // Count after this edge
	logic next_half; // Half-full crossing this edge
	logic at_max; // Counter is pinned at its ceiling
	localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

	assign at_max = (cnt.count == MAX);
	// RULE11 clear on read
	// A count arriving with the clear survives as one, so nothing is lost
	assign next_count = cnt.clr ? (cnt.inc ? ONE : '0) :
		// RULE9 RULE14 stop at ceiling
		((cnt.inc && !at_max) ? cnt.count + ONE : cnt.count);
	// RULE10 RULE15 half-full crossing
	assign next_half = cnt.inc && !cnt.clr && (cnt.count == HALF);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	// Count and pulse freeze while the enable is low
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			cnt.count <= '0;
			cnt.half_evt <= 1'b0;
		end else if (i_ce) begin
			cnt.count <= next_count;
			cnt.half_evt <= next_half;
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_cnt_sat;
		@(posedge i_clk) disable iff (i_rst)
		i_ce && at_max && cnt.inc && !cnt.clr |=> cnt.count == MAX;
	endproperty
	a_cnt_sat: assert property (p_cnt_sat) // RULE9 RULE14
		else $error("counter left its ceiling");

	property p_cnt_inc;
		@(posedge i_clk) disable iff (i_rst)
		i_ce && cnt.inc && !cnt.clr && !at_max
		|=> cnt.count == $past(cnt.count) + ONE;
	endproperty
	a_cnt_inc: assert property (p_cnt_inc) // RULE8 RULE12
		else $error("counter missed an event");

	property p_cnt_clr;
		@(posedge i_clk) disable iff (i_rst)
		i_ce && cnt.clr ##1 i_ce |-> cnt.count <= ONE;
	endproperty
	a_cnt_clr: assert property (p_cnt_clr) // RULE11
		else $error("counter not cleared by read");

	property p_cnt_half;
		@(posedge i_clk) disable iff (i_rst)
		i_ce && cnt.inc && !cnt.clr && cnt.count == HALF |=> cnt.half_evt;
	endproperty
	a_cnt_half: assert property (p_cnt_half) // RULE10 RULE15
		else $error("half-full pulse missing");

	c_cnt_sat: cover property (@(posedge i_clk) disable iff (i_rst)
		i_ce && at_max && cnt.inc);

endmodule : pes_sat_counter

// file: pes_regs.sv
// Event status/enable registers and receive error counters of a PHY.
// Assumes event inputs are synchronous to i_clk; register access over
// Avalon-MM with waitrequest, one 32-bit word per register.
//
// Behaviour
// RULE1: undervoltage latches status bit 15
// RULE2: overvoltage latches status bit 14
// RULE3: overtemperature latches status bit 11
// RULE4: sleep event latches status bit 10
// RULE5: polarity change latches status bit 9
// RULE6: jabber latches status bit 8
// RULE7: enable bits 7,6,3..0 gate each event
// RULE8: false carrier count, 8 bits, increments
// RULE9: false carrier count stops at 0xFF
// RULE10: false carrier passing 0x7F raises event
// RULE11: reading a counter clears it
// RULE12: receive errors counted in 16 bits
// RULE13: no receive error count in loopback
// RULE14: receive error count stops at ceiling
// RULE15: receive error passing 0x7FFF raises event (default ceiling 0x0FFF is below it, so it never fires)
// RULE16: half-full events set first-register bits 9,8
// RULE17: status read clears unless event persists
// RULE18: interrupt while enabled flag is set
`timescale 1ns/1ps
module pes_regs #(
	parameter logic [15:0] RX_CEIL = pes_pkg::RX_MAX
) (
	// Clock, reset and enable
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_ce,
	// Avalon-MM slave
	input wire logic [7:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	// Supply, temperature and link events
	input wire logic i_undervolt,
	input wire logic i_overvolt,
	input wire logic i_overtemp,
	input wire logic i_sleep_evt,
	input wire logic i_rx_polarity,
	input wire logic i_jabber,
	// Receive path
	input wire logic i_false_carrier,
	input wire logic i_rx_dv,
	input wire logic i_rx_symbol_err,
	input wire logic i_mac_loopback,
	// Interrupt
	output logic o_irq
);
	import pes_pkg::*;

	// ----------------------------------------------------------------
	// Bus decode
	// ----------------------------------------------------------------
	logic [5:0] idx; // Word index of the access
	logic rd_first; // First cycle of a read: snapshot and clear
	logic wr_take; // Write takes effect on this edge
	logic [15:0] wmask; // Byte-lane mask of the low half word
	logic [15:0] wdata; // Masked write data
	logic hit_st1, hit_st2, hit_fc, hit_rx, hit_stc; // Register hits

	assign idx = i_avs_address[7:2];
	assign rd_first = i_avs_read && o_avs_waitrequest;
	assign wr_take = i_avs_write && !o_avs_waitrequest;
	assign wmask = {{8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
	assign wdata = i_avs_writedata[15:0] & wmask;
	assign hit_st1 = (idx == IDX_STAT1);
	assign hit_st2 = (idx == IDX_STAT2);
	assign hit_fc = (idx == IDX_FCNT);
	assign hit_rx = (idx == IDX_RXERR);
	assign hit_stc = (idx == IDX_STC);

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	logic [15:0] flags2; // Latched event flags, second register
	logic [15:0] en2; // Enables, second register
	logic [15:0] flags1; // Latched half-full flags, first register
	logic [15:0] en1; // Half-full enables, first register
	logic [15:0] stc; // Self-test control, layout only
	logic pol_q; // Last seen receive polarity
	logic pol_seen; // Polarity has been sampled once

	// ----------------------------------------------------------------
	// Counters
	// ----------------------------------------------------------------
	pes_cnt_if #(.W(FC_W)) fc_if ();
	pes_cnt_if #(.W(RX_W)) rx_if ();

	// RULE8 false carrier counting
	assign fc_if.inc = i_false_carrier;
	// RULE11 clear on read
	assign fc_if.clr = rd_first && hit_fc;
	// RULE12 RULE13 error gated by loopback
	assign rx_if.inc = i_rx_dv && i_rx_symbol_err && !i_mac_loopback;
	assign rx_if.clr = rd_first && hit_rx;

	// RULE9 RULE10 eight-bit counter
	pes_sat_counter #(.W(FC_W), .MAX(FC_MAX), .HALF(FC_HALF)) u_fc (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.cnt(fc_if.ctr)
	);

	// RULE14 RULE15 sixteen-bit counter
	// Ceiling is a parameter: if it sits below the half-full mark the
	// half-full event can never fire, which is why it is adjustable
	pes_sat_counter #(.W(RX_W), .MAX(RX_CEIL), .HALF(RX_HALF)) u_rx (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_ce(i_ce),
		.cnt(rx_if.ctr)
	);

	// ----------------------------------------------------------------
	// Event and status next values
	// ----------------------------------------------------------------
	logic pol_chg; // Polarity differs from last sample
	logic [15:0] ev2; // Event vector aligned to second register
	logic [15:0] ev1; // Event vector aligned to first register
	logic [15:0] next_flags2, next_flags1;
	logic [15:0] next_en2, next_en1, next_stc;
	logic next_irq;

	// First sample after reset is not a change
	assign pol_chg = pol_seen && (i_rx_polarity != pol_q);
	// RULE1 RULE2 RULE3 RULE4 RULE5 RULE6 event placement
	assign ev2 = {i_undervolt, i_overvolt, 2'b00, i_overtemp,
		i_sleep_evt, pol_chg, i_jabber, 8'h00};
	// RULE16 half-full placement
	assign ev1 = {6'h00, fc_if.half_evt, rx_if.half_evt, 8'h00};
	// RULE17 set wins over read clear
	assign next_flags2 = ev2 | (flags2 & ~{16{rd_first && hit_st2}});
	assign next_flags1 = ev1 | (flags1 & ~{16{rd_first && hit_st1}});
	// RULE7 writable enables
	assign next_en2 = (wr_take && hit_st2) ?
		(en2 & ~(wmask & EN2_MASK)) | (wdata & EN2_MASK) : en2;
	assign next_en1 = (wr_take && hit_st1) ?
		(en1 & ~(wmask & EN1_MASK)) | (wdata & EN1_MASK) : en1;
	assign next_stc = (wr_take && hit_stc) ?
		(stc & ~(wmask & STC_MASK)) | (wdata & STC_MASK) : stc;
	// RULE18 RULE7 enabled flags drive the interrupt
	// Status bits 15:8 line up with enables 7:0 bit for bit
	assign next_irq = (|(flags2[15:8] & en2[7:0])) ||
		(|(flags1[9:8] & en1[1:0]));

	// ----------------------------------------------------------------
	// Read mux
	// ----------------------------------------------------------------
	logic [15:0] rd_mux; // Word seen by a read; unmapped reads zero

	assign rd_mux = hit_st2 ? (flags2 | en2) :
		hit_st1 ? (flags1 | en1) :
		hit_fc ? {8'h00, fc_if.count} :
		hit_rx ? rx_if.count :
		hit_stc ? (stc | STC_RSV_VAL) : REG_RST;

	// ----------------------------------------------------------------
	// Status, enable and control state
	// ----------------------------------------------------------------
	// All state holds while the clock enable is low
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			flags2 <= REG_RST;
			flags1 <= REG_RST;
			en2 <= REG_RST;
			en1 <= REG_RST;
			stc <= REG_RST;
		end else if (i_ce) begin
			flags2 <= next_flags2;
			flags1 <= next_flags1;
			en2 <= next_en2;
			en1 <= next_en1;
			stc <= next_stc;
		end
	end

	// Polarity history for change detection
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			pol_q <= 1'b0;
			pol_seen <= 1'b0;
		end else if (i_ce) begin
			pol_q <= i_rx_polarity;
			pol_seen <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Bus answer and interrupt
	// ----------------------------------------------------------------
	// Every access waits exactly one cycle; the snapshot is taken on
	// the same edge as the clear, so no read loses a counted event
	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata <= 32'h0000_0000;
			o_irq <= 1'b0;
		end else if (i_ce) begin
			o_avs_waitrequest <= !((i_avs_read || i_avs_write) &&
				o_avs_waitrequest);
			o_irq <= next_irq;
			if (rd_first) begin
				o_avs_readdata <= {16'h0000, rd_mux};
			end
		end
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	property p_uv;
		@(posedge i_clk) disable iff (i_rst)
		i_ce && i_undervolt |=> flags2[BIT_UV];
	endproperty
	a_uv: assert property (p_uv) // RULE1
		else $error("undervoltage flag not set");

	property p_ov;
		@(posedge i_clk) disable iff (i_rst)
		i_ce && i_overvolt |=> flags2[BIT_OV] && (flags2 | en2) != 16'h0000;
	endproperty
	a_ov: assert property (p_ov) // RULE2
		else $error("overvoltage flag not set");

	property p_ot;
		@(posedge i_clk) disable iff (i_rst)
		i_ce && i_overtemp |=> flags2[BIT_OT];
	endproperty
	a_ot: assert property (p_ot) // RULE3
		else $error("overtemperature flag not set");

	property p_sleep;
		@(posedge i_clk) disable iff (i_rst)
		i_ce && i_sleep_evt |=> flags2[BIT_SLEEP];
	endproperty
	a_sleep: assert property (p_sleep) // RULE4
		else $error("sleep flag not set");

	property p_pol;
		@(posedge i_clk) disable iff (i_rst)
		i_ce ##1 i_ce && $changed(i_rx_polarity) |=> flags2[BIT_POL];
	endproperty
	a_pol: assert property (p_pol) // RULE5
		else $error("polarity change flag not set");

	property p_jab;
		@(posedge i_clk) disable iff (i_rst)
		i_ce && i_jabber |=> flags2[BIT_JAB];
	endproperty
	a_jab: assert property (p_jab) // RULE6
		else $error("jabber flag not set");

	property p_gate;
		@(posedge i_clk) disable iff (i_rst)
		i_ce && en2[7:0] == 8'h00 && en1[1:0] == 2'b00 |=> !o_irq;
	endproperty
	a_gate: assert property (p_gate) // RULE7
		else $error("interrupt raised with all enables off");

	property p_loop;
		@(posedge i_clk) disable iff (i_rst)
		i_ce && i_mac_loopback && !rx_if.clr |=> $stable(rx_if.count);
	endproperty
	a_loop: assert property (p_loop) // RULE13
		else $error("receive errors counted in loopback");

	property p_hf;
		@(posedge i_clk) disable iff (i_rst)
		i_ce && fc_if.half_evt |=> flags1[BIT_FC_HF];
	endproperty
	a_hf: assert property (p_hf) // RULE16
		else $error("half-full flag not set");

	property p_hold;
		@(posedge i_clk) disable iff (i_rst)
		i_ce && flags2[BIT_UV] && !(rd_first && hit_st2) |=> flags2[BIT_UV];
	endproperty
	a_hold: assert property (p_hold) // RULE17
		else $error("flag dropped without a read");

	property p_irq;
		@(posedge i_clk) disable iff (i_rst)
		i_ce && (flags2[BIT_JAB] && en2[EN_JAB]) |=> o_irq;
	endproperty
	a_irq: assert property (p_irq) // RULE18
		else $error("interrupt missing for enabled flag");

	c_read: cover property (@(posedge i_clk) disable iff (i_rst)
		rd_first && hit_fc && fc_if.count != 8'h00);
	c_write: cover property (@(posedge i_clk) disable iff (i_rst)
		wr_take && hit_st2);
	c_irq: cover property (@(posedge i_clk) disable iff (i_rst)
		$rose(o_irq));

endmodule : pes_regs

// file: test_phy_event_status_and_error_counters.sv
// Self-checking bench for the event status and error counter bank.
// Assumes pes_pkg and pes_regs are compiled first; one 40 MHz clock.
`timescale 1ns/1ps
module test_phy_event_status_and_error_counters;
	import pes_pkg::*;

	// ----------------------------------------------------------------
	// Stimulus and observation signals
	// ----------------------------------------------------------------
	logic i_clk = 1'b0; // Bench clock
	logic i_rst = 1'b1; // Held for two edges
	logic [7:0] addr = 8'h00; // Byte address
	logic rd = 1'b0; // Read request
	logic wr = 1'b0; // Write request
	logic [31:0] wdata = 32'h0000_0000; // Write data
	logic [3:0] be = 4'hF; // Byte lanes
	logic [5:0] ev = 6'h00; // Event lines, bit 1 unused (polarity apart)
	logic pol = 1'b0; // Receive polarity level
	logic [3:0] rxv = 4'h0; // {false carrier, dv, symbol error, loopback}
	logic ce = 1'b1; // Clock enable, dropped once to check freezing
	logic [31:0] rdata; // Read data from the bank
	logic waitreq; // Bus wait
	logic irq; // Interrupt line
	logic [15:0] exp_q[$]; // Expected read values, oldest first
	int err_count = 0; // Mismatches seen
	int samples_checked = 0; // Comparisons made
	int seed = 3776; // Fixed seed keeps runs repeatable
	// Flag and enable position per event index (0 jabber .. 5 undervolt)
	int flag_at[6] = '{BIT_JAB, BIT_POL, BIT_SLEEP, BIT_OT, BIT_OV, BIT_UV};
	int en_at[6] = '{EN_JAB, EN_POL, EN_SLEEP, EN_OT, EN_OV, EN_UV};

	// Clock enable is driven so that a frozen stretch can be checked
	pes_regs #(.RX_CEIL(RX_MAX)) i_pes_regs (
		.i_clk(i_clk), .i_rst(i_rst), .i_ce(ce),
		.i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
		.i_avs_writedata(wdata), .i_avs_byteenable(be),
		.o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
		.i_undervolt(ev[5]), .i_overvolt(ev[4]), .i_overtemp(ev[3]),
		.i_sleep_evt(ev[2]), .i_rx_polarity(pol), .i_jabber(ev[0]),
		.i_false_carrier(rxv[3]), .i_rx_dv(rxv[2]),
		.i_rx_symbol_err(rxv[1]), .i_mac_loopback(rxv[0]), .o_irq(irq)
	);

	// 25 ns period
	initial begin
		forever #12.5 i_clk = ~i_clk;
	end

	// ----------------------------------------------------------------
	// Report, compare and bus tasks
	// ----------------------------------------------------------------
	task automatic wrap_up;
		if (err_count == 0 && samples_checked > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : wrap_up

	task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
		samples_checked++;
		if (g !== e) begin
			err_count++;
			$display("FAIL t=%0t exp=%h got=%h", $time, e, g);
		end
	endtask : chk_rd

	task automatic chk_irq(input logic e);
		samples_checked++;
		if (irq !== e) begin
			err_count++;
			$display("FAIL t=%0t exp=%h got=%h", $time, e, irq);
		end
	endtask : chk_irq

	// One access; holds everything until waitrequest is sampled low
	task automatic bus(input logic [5:0] idx, input logic w,
		input logic [15:0] d, input logic [3:0] lanes);
		int n;
		@(posedge i_clk);
		addr <= {idx, 2'b00};
		rd <= ~w;
		wr <= w;
		wdata <= {16'h0000, d};
		be <= lanes;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (waitreq !== 1'b0 && n < 64);
		// A slave that never answers ends the run
		if (waitreq !== 1'b0) begin
			err_count++;
			wrap_up();
		end
		rd <= 1'b0;
		wr <= 1'b0;
	endtask : bus

	task automatic wr_reg(input logic [5:0] idx, input logic [15:0] d);
		bus(idx, 1'b1, d, 4'hF);
	endtask : wr_reg

	// Expected value is noted before the request goes out
	task automatic rd_reg(input logic [5:0] idx, input logic [15:0] e);
		exp_q.push_back(e);
		bus(idx, 1'b0, 16'h0000, 4'hF);
	endtask : rd_reg

	// One-cycle event (polarity toggles instead), then let irq settle
	task automatic pulse(input int k);
		@(posedge i_clk);
		if (k == 1) begin
			pol <= ~pol;
		end else begin
			ev[k] <= 1'b1;
		end
		@(posedge i_clk);
		ev <= 6'h00;
		repeat (3) @(posedge i_clk);
	endtask : pulse

	// Hold a receive pattern for exactly n sampled edges
	task automatic drive_rx(input int n, input logic [3:0] v);
		@(posedge i_clk);
		rxv <= v;
		repeat (n) @(posedge i_clk);
		rxv <= 4'h0;
	endtask : drive_rx

	// ----------------------------------------------------------------
	// Read monitor: takes the oldest note when read data stands
	// ----------------------------------------------------------------
	always @(posedge i_clk) begin
		if (rd === 1'b1 && waitreq === 1'b0) begin
			if (exp_q.size() == 0) begin
				err_count++;
				$display("FAIL t=%0t exp=%h got=%h", $time, 32'h0, rdata);
			end else begin
				chk_rd({16'h0000, exp_q.pop_front()}, rdata);
			end
		end
	end

	// ----------------------------------------------------------------
	// Main sequence
	// ----------------------------------------------------------------
	initial begin
		logic [15:0] m;
		int k;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		chk_irq(1'b0);
		// Reset values, then an unmapped index that must read zero
		rd_reg(IDX_STAT1, REG_RST);
		rd_reg(IDX_STAT2, REG_RST);
		rd_reg(IDX_FCNT, REG_RST);
		rd_reg(IDX_RXERR, REG_RST);
		rd_reg(IDX_STC, 16'h0100);
		rd_reg(6'h3F, 16'h0000);
		// Upper lane only: lower byte must stay untouched
		bus(IDX_STC, 1'b1, 16'hFFFF, 4'b0010);
		rd_reg(IDX_STC, 16'h7100);
		// Only enable bits take a write
		wr_reg(IDX_STAT2, 16'hFFFF);
		rd_reg(IDX_STAT2, EN2_MASK);
		for (k = 0; k < 6; k++) begin
			pulse(k);
			chk_irq(1'b1);
			rd_reg(IDX_STAT2, EN2_MASK | (16'h0001 << flag_at[k]));
			rd_reg(IDX_STAT2, EN2_MASK);
			repeat (2) @(posedge i_clk);
			chk_irq(1'b0);
		end
		// Random enable masks against random events
		repeat (8) begin
			m = 16'($random(seed)) & EN2_MASK;
			k = {$random(seed)} % 6;
			wr_reg(IDX_STAT2, m);
			pulse(k);
			chk_irq(m[en_at[k]]);
			rd_reg(IDX_STAT2, m | (16'h0001 << flag_at[k]));
		end
		// Event still present during the clearing read
		wr_reg(IDX_STAT2, 16'h0000);
		@(posedge i_clk);
		ev[5] <= 1'b1;
		rd_reg(IDX_STAT2, 16'h8000);
		ev <= 6'h00;
		chk_irq(1'b0);
		rd_reg(IDX_STAT2, 16'h8000);
		rd_reg(IDX_STAT2, 16'h0000);
		// False carrier: half-full boundary, saturation, clear
		wr_reg(IDX_STAT1, 16'hFFFF);
		rd_reg(IDX_STAT1, EN1_MASK);
		drive_rx(127, 4'b1000);
		repeat (6) @(posedge i_clk);
		chk_irq(1'b0);
		drive_rx(1, 4'b1000);
		repeat (6) @(posedge i_clk);
		chk_irq(1'b1);
		rd_reg(IDX_STAT1, EN1_MASK | 16'h0200);
		drive_rx(200, 4'b1000);
		rd_reg(IDX_FCNT, {8'h00, FC_MAX});
		rd_reg(IDX_FCNT, 16'h0000);
		drive_rx(3, 4'b1000);
		rd_reg(IDX_FCNT, 16'h0003);
		// Receive errors: qualified counting, loopback, ceiling
		drive_rx(5, 4'b0110);
		rd_reg(IDX_RXERR, 16'h0005);
		drive_rx(5, 4'b0111);
		rd_reg(IDX_RXERR, 16'h0000);
		drive_rx(5, 4'b0100);
		drive_rx(5, 4'b0010);
		rd_reg(IDX_RXERR, 16'h0000);
		// Clock enable low: qualified errors must not be counted
		ce <= 1'b0;
		drive_rx(5, 4'b0110);
		ce <= 1'b1;
		rd_reg(IDX_RXERR, 16'h0000);
		drive_rx(4200, 4'b0110);
		rd_reg(IDX_RXERR, RX_MAX);
		rd_reg(IDX_RXERR, 16'h0000);
		rd_reg(IDX_STAT1, EN1_MASK);
		// Mid-run reset with an enabled flag pending
		wr_reg(IDX_STAT2, EN2_MASK);
		pulse(0);
		chk_irq(1'b1);
		@(posedge i_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		chk_irq(1'b0);
		rd_reg(IDX_STAT2, REG_RST);
		rd_reg(IDX_STAT1, REG_RST);
		wrap_up();
	end

endmodule : test_phy_event_status_and_error_counters
